// ==== design/apgc_pkg.sv ====
// Package: register map, field positions, reset values and divider defaults
package apgc_pkg;
	// Register addresses on the control port
	localparam logic [7:0] APGC_ADDR_DEEMPH_SRC  = 8'h07;
	localparam logic [7:0] APGC_ADDR_PIN_MUTE    = 8'h08;
	localparam logic [7:0] APGC_ADDR_PORT_CLOCK  = 8'h09;
	// Field positions
	localparam int APGC_BIT_DEEMPH_ENABLE        = 4;
	localparam int APGC_BIT_SERIAL_OUT_SRC       = 0;
	localparam int APGC_BIT_GP_PIN2_OUTPUT_EN    = 5;
	localparam int APGC_BIT_MUTE_GATE_ENABLE     = 4;
	localparam int APGC_BIT_GP_PIN0_OUTPUT_EN    = 3;
	localparam int APGC_BIT_BIT_CLOCK_INVERT     = 5;
	localparam int APGC_BIT_BIT_CLOCK_DRIVE_EN   = 4;
	localparam int APGC_BIT_FRAME_CLOCK_DRIVE_EN = 0;
	// Reset value of every register: reserved bits are stored but steer nothing
	localparam logic [7:0] APGC_RESET_VALUE      = 8'h00;
	// Divider defaults: 64 bit clocks per frame
	localparam int APGC_BCLK_DIV_DEFAULT         = 4;
	localparam int APGC_FRAME_DIV_DEFAULT        = 64;
	// Default de-emphasis coefficient set, tuned for 44.1 kHz
	localparam logic [15:0] APGC_DEEMPH_B0_44K1  = 16'h4000;
	localparam logic [15:0] APGC_DEEMPH_B1_44K1  = 16'hDC00;
	localparam logic [15:0] APGC_DEEMPH_A1_44K1  = 16'h2C00;
endpackage

// ==== design/apgc_clock_divider.sv ====
// Module: programmable clock divider producing a toggling output and edge strobes
`timescale 1ns/1ps
module apgc_clock_divider #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic             enable_i,
	// Control
	input  wire logic             run_i,
	input  wire logic             tick_i,
	input  wire logic [WIDTH-1:0] factor_i,
	// Result
	output logic                  clock_o,
	output logic                  rise_o,
	output logic                  fall_o
);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic             next_clock;
	logic             next_rise;
	logic             next_fall;
	logic [WIDTH-1:0] half;

	always_comb begin
		half       = factor_i >> 1;
		next_count = count;
		next_clock = clock_o;
		next_rise  = 1'b0;
		next_fall  = 1'b0;
		// Factors below two cannot make a square wave, so the divider clears its count and drives its output low
		if (!run_i || factor_i < WIDTH'(2)) begin
			next_count = '0;
			next_clock = 1'b0;
		end else if (tick_i) begin
			if (count == factor_i - WIDTH'(1)) begin
				next_count = '0;
				next_clock = 1'b0;
				next_fall  = clock_o;
			end else begin
				next_count = count + WIDTH'(1);
				if (count == half - WIDTH'(1)) begin
					next_clock = 1'b1;
					next_rise  = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			count   <= '0;
			clock_o <= 1'b0;
			rise_o  <= 1'b0;
			fall_o  <= 1'b0;
		end else if (enable_i) begin
			count   <= next_count;
			clock_o <= next_clock;
			rise_o  <= next_rise;
			fall_o  <= next_fall;
		end
	end
endmodule

// ==== design/apgc_audio_port_ctrl.sv ====
// Module: audio port control registers with pin steering, mute gate and master clocks
`timescale 1ns/1ps
module apgc_audio_port_ctrl
	import apgc_pkg::*;
#(
	parameter int SAMPLE_WIDTH = 16,
	parameter int DIV_WIDTH    = 8
) (
	// Clock, reset and enable
	input  wire logic                    clk_i,
	input  wire logic                    reset_i,
	input  wire logic                    enable_i,
	// Control port register access
	input  wire logic                    reg_write_i,
	input  wire logic [7:0]              reg_addr_i,
	input  wire logic [7:0]              reg_wdata_i,
	output logic      [7:0]              reg_rdata_o,
	// Coefficient memory writes
	input  wire logic                    coef_write_i,
	input  wire logic [1:0]              coef_index_i,
	input  wire logic [15:0]             coef_wdata_i,
	// Divider settings held elsewhere
	input  wire logic                    bclk_div_run_i,
	input  wire logic                    frame_div_run_i,
	input  wire logic [DIV_WIDTH-1:0]    bclk_div_factor_i,
	input  wire logic [DIV_WIDTH-1:0]    frame_div_factor_i,
	// Audio samples
	input  wire logic                    sample_valid_i,
	input  wire logic [SAMPLE_WIDTH-1:0] input_sample_i,
	input  wire logic [SAMPLE_WIDTH-1:0] processed_sample_i,
	output logic      [SAMPLE_WIDTH-1:0] filtered_sample_o,
	output logic      [SAMPLE_WIDTH-1:0] serial_data_out_o,
	// General pins
	input  wire logic                    general_pin_0_i,
	output logic                         general_pin_0_o,
	output logic                         general_pin_0_oe_o,
	input  wire logic                    general_pin_2_i,
	output logic                         general_pin_2_o,
	output logic                         general_pin_2_oe_o,
	output logic      [1:0]              general_pin_in_o,
	// Mute toward the power stage
	input  wire logic                    converter_mute_i,
	output logic                         power_stage_mute_o,
	// Serial port clocks
	input  wire logic                    bit_clock_i,
	output logic                         bit_clock_o,
	output logic                         bit_clock_oe_o,
	input  wire logic                    frame_clock_i,
	output logic                         frame_clock_o,
	output logic                         frame_clock_oe_o,
	output logic                         launch_strobe_o
);
	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [7:0] deemphasis_and_output_source;
	logic [7:0] pin_direction_and_mute_gate;
	logic [7:0] serial_port_clock_config;
	logic [7:0] next_deemphasis_and_output_source;
	logic [7:0] next_pin_direction_and_mute_gate;
	logic [7:0] next_serial_port_clock_config;
	logic [7:0] next_reg_rdata;

	always_comb begin
		next_deemphasis_and_output_source = deemphasis_and_output_source;
		next_pin_direction_and_mute_gate  = pin_direction_and_mute_gate;
		next_serial_port_clock_config     = serial_port_clock_config;
		// Reserved bits are kept as written so software reads them back
		if (reg_write_i) begin
			case (reg_addr_i)
				APGC_ADDR_DEEMPH_SRC: next_deemphasis_and_output_source = reg_wdata_i;
				APGC_ADDR_PIN_MUTE:   next_pin_direction_and_mute_gate  = reg_wdata_i;
				APGC_ADDR_PORT_CLOCK: next_serial_port_clock_config     = reg_wdata_i;
				default: ;
			endcase
		end
		case (reg_addr_i)
			APGC_ADDR_DEEMPH_SRC: next_reg_rdata = deemphasis_and_output_source;
			APGC_ADDR_PIN_MUTE:   next_reg_rdata = pin_direction_and_mute_gate;
			APGC_ADDR_PORT_CLOCK: next_reg_rdata = serial_port_clock_config;
			default:              next_reg_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			deemphasis_and_output_source <= APGC_RESET_VALUE;
			pin_direction_and_mute_gate  <= APGC_RESET_VALUE;
			serial_port_clock_config     <= APGC_RESET_VALUE;
			reg_rdata_o                  <= 8'h00;
		end else if (enable_i) begin
			deemphasis_and_output_source <= next_deemphasis_and_output_source;
			pin_direction_and_mute_gate  <= next_pin_direction_and_mute_gate;
			serial_port_clock_config     <= next_serial_port_clock_config;
			reg_rdata_o                  <= next_reg_rdata;
		end
	end

	logic deemph_enable;
	logic serial_out_source_sel;
	logic gp_pin2_output_en;
	logic mute_gate_enable;
	logic gp_pin0_output_en;
	logic bit_clock_invert;
	logic bit_clock_drive_en;
	logic frame_clock_drive_en;
	assign deemph_enable         = deemphasis_and_output_source[APGC_BIT_DEEMPH_ENABLE];
	assign serial_out_source_sel = deemphasis_and_output_source[APGC_BIT_SERIAL_OUT_SRC];
	assign gp_pin2_output_en     = pin_direction_and_mute_gate[APGC_BIT_GP_PIN2_OUTPUT_EN];
	assign mute_gate_enable      = pin_direction_and_mute_gate[APGC_BIT_MUTE_GATE_ENABLE];
	assign gp_pin0_output_en     = pin_direction_and_mute_gate[APGC_BIT_GP_PIN0_OUTPUT_EN];
	assign bit_clock_invert      = serial_port_clock_config[APGC_BIT_BIT_CLOCK_INVERT];
	assign bit_clock_drive_en    = serial_port_clock_config[APGC_BIT_BIT_CLOCK_DRIVE_EN];
	assign frame_clock_drive_en  = serial_port_clock_config[APGC_BIT_FRAME_CLOCK_DRIVE_EN];

	// ------------------------------------------------------------
	// De-emphasis filter: first-order section, Q2.14 coefficients
	// ------------------------------------------------------------
	logic signed [15:0]             coef_mem [3];
	logic signed [15:0]             next_coef_mem [3];
	logic signed [SAMPLE_WIDTH-1:0] prev_in;
	logic signed [SAMPLE_WIDTH-1:0] prev_out;
	logic signed [SAMPLE_WIDTH-1:0] next_prev_in;
	logic signed [SAMPLE_WIDTH-1:0] next_prev_out;
	logic signed [SAMPLE_WIDTH+17:0] acc;
	logic signed [SAMPLE_WIDTH-1:0] filt;
	logic [SAMPLE_WIDTH-1:0]        next_filtered;

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			next_coef_mem[i] = coef_mem[i];
		end
		// Index 3 is unmapped and ignored
		if (coef_write_i && coef_index_i != 2'd3) begin
			next_coef_mem[coef_index_i] = coef_wdata_i;
		end
		// Widen before multiplying: a product keeps only its operands' width
		acc = (SAMPLE_WIDTH+18)'(coef_mem[0]) * (SAMPLE_WIDTH+18)'($signed(input_sample_i))
			+ (SAMPLE_WIDTH+18)'(coef_mem[1]) * (SAMPLE_WIDTH+18)'(prev_in)
			+ (SAMPLE_WIDTH+18)'(coef_mem[2]) * (SAMPLE_WIDTH+18)'(prev_out);
		filt          = acc[SAMPLE_WIDTH+13:14];
		next_prev_in  = prev_in;
		next_prev_out = prev_out;
		next_filtered = filtered_sample_o;
		if (sample_valid_i) begin
			next_prev_in  = $signed(input_sample_i);
			next_prev_out = filt;
			// Bypass still tracks history so enabling causes no step
			next_filtered = deemph_enable ? filt : input_sample_i;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			coef_mem[0]       <= APGC_DEEMPH_B0_44K1;
			coef_mem[1]       <= APGC_DEEMPH_B1_44K1;
			coef_mem[2]       <= APGC_DEEMPH_A1_44K1;
			prev_in           <= '0;
			prev_out          <= '0;
			filtered_sample_o <= '0;
		end else if (enable_i) begin
			coef_mem          <= next_coef_mem;
			prev_in           <= next_prev_in;
			prev_out          <= next_prev_out;
			filtered_sample_o <= next_filtered;
		end
	end

	// ------------------------------------------------------------
	// Master clock generation
	// ------------------------------------------------------------
	logic bclk_gen;
	logic bclk_rise;
	logic bclk_fall;
	logic frame_gen;
	logic bclk_run;

	assign bclk_run = bclk_div_run_i && bit_clock_drive_en;

	apgc_clock_divider #(
		.WIDTH (DIV_WIDTH)
	) u_bclk_div (
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.enable_i (enable_i),
		.run_i    (bclk_run),
		.tick_i   (1'b1),
		.factor_i (bclk_div_factor_i),
		.clock_o  (bclk_gen),
		.rise_o   (bclk_rise),
		.fall_o   (bclk_fall)
	);

	// Frame divider counts bit clock periods on their falling edge
	apgc_clock_divider #(
		.WIDTH (DIV_WIDTH)
	) u_frame_div (
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.enable_i (enable_i),
		.run_i    (frame_div_run_i && bclk_run),
		.tick_i   (bclk_fall),
		.factor_i (frame_div_factor_i),
		.clock_o  (frame_gen),
		.rise_o   (),
		.fall_o   ()
	);

	// ------------------------------------------------------------
	// Pins, mute gate, serial output and launch edge
	// ------------------------------------------------------------
	logic bclk_now;
	logic bclk_prev;
	logic next_launch;

	always_comb begin
		bclk_now    = bit_clock_drive_en ? bclk_gen : bit_clock_i;
		// Launch edge follows polarity; external source uses the same edge
		next_launch = bit_clock_invert ? (bclk_now && !bclk_prev)
			: (!bclk_now && bclk_prev);
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			bclk_prev          <= 1'b0;
			launch_strobe_o    <= 1'b0;
			serial_data_out_o  <= '0;
			general_pin_0_o    <= 1'b0;
			general_pin_0_oe_o <= 1'b0;
			general_pin_2_o    <= 1'b0;
			general_pin_2_oe_o <= 1'b0;
			general_pin_in_o   <= 2'b00;
			power_stage_mute_o <= 1'b0;
			bit_clock_o        <= 1'b0;
			bit_clock_oe_o     <= 1'b0;
			frame_clock_o      <= 1'b0;
			frame_clock_oe_o   <= 1'b0;
		end else if (enable_i) begin
			bclk_prev          <= bclk_now;
			launch_strobe_o    <= next_launch;
			serial_data_out_o  <= serial_out_source_sel ? input_sample_i
				: processed_sample_i;
			// Pins carry the serial output bit when driven
			general_pin_0_o    <= serial_data_out_o[SAMPLE_WIDTH-1];
			general_pin_0_oe_o <= gp_pin0_output_en;
			general_pin_2_o    <= serial_data_out_o[SAMPLE_WIDTH-1];
			general_pin_2_oe_o <= gp_pin2_output_en;
			general_pin_in_o   <= {gp_pin2_output_en ? 1'b0 : general_pin_2_i,
				gp_pin0_output_en ? 1'b0 : general_pin_0_i};
			power_stage_mute_o <= mute_gate_enable && converter_mute_i;
			bit_clock_o        <= bit_clock_invert ? !bclk_gen : bclk_gen;
			bit_clock_oe_o     <= bit_clock_drive_en;
			frame_clock_o      <= frame_gen;
			frame_clock_oe_o   <= frame_clock_drive_en;
		end
	end

	logic unused_rise;
	assign unused_rise = bclk_rise;
endmodule

// ==== sim/apgc_audio_port_ctrl_monitor.sv ====
// Checker: port-level relations of the audio port control block
`timescale 1ns/1ps
module apgc_audio_port_ctrl_monitor
	import apgc_pkg::*;
#(
	parameter int DIV_WIDTH = 8
) (
	// Watched ports
	input wire logic                 clk_i,
	input wire logic                 reset_i,
	input wire logic                 enable_i,
	input wire logic                 reg_write_i,
	input wire logic [7:0]           reg_addr_i,
	input wire logic [7:0]           reg_wdata_i,
	input wire logic [7:0]           reg_rdata_o,
	input wire logic                 bclk_div_run_i,
	input wire logic [DIV_WIDTH-1:0] bclk_div_factor_i,
	input wire logic                 converter_mute_i,
	input wire logic                 power_stage_mute_o,
	input wire logic                 general_pin_0_oe_o,
	input wire logic                 general_pin_2_oe_o,
	input wire logic                 bit_clock_o,
	input wire logic                 bit_clock_oe_o,
	input wire logic                 frame_clock_oe_o,
	input wire logic                 launch_strobe_o
);
	// ---------------------------------------------
	// Shadow registers
	// ---------------------------------------------
	logic [7:0] r7, r8, r9, next_r7, next_r8, next_r9, rd;
	logic       take, run4;
	assign take = enable_i && reg_write_i;
	assign run4 = bclk_div_run_i && bclk_div_factor_i == DIV_WIDTH'(4);
	assign rd = reg_addr_i == APGC_ADDR_DEEMPH_SRC ? r7 : reg_addr_i == APGC_ADDR_PIN_MUTE ? r8 :
		reg_addr_i == APGC_ADDR_PORT_CLOCK ? r9 : 8'h00;
	always_comb begin
		next_r7 = (take && reg_addr_i == APGC_ADDR_DEEMPH_SRC) ? reg_wdata_i : r7;
		next_r8 = (take && reg_addr_i == APGC_ADDR_PIN_MUTE) ? reg_wdata_i : r8;
		next_r9 = (take && reg_addr_i == APGC_ADDR_PORT_CLOCK) ? reg_wdata_i : r9;
	end
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			r7 <= 8'h00;
			r8 <= 8'h00;
			r9 <= 8'h00;
		end else begin
			r7 <= next_r7;
			r8 <= next_r8;
			r9 <= next_r9;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	pin0_dir_a: assert property ($past(enable_i) |-> general_pin_0_oe_o == $past(r8[3]))
		else $error("pin 0 direction wrong");
	pin2_dir_a: assert property ($past(enable_i) |-> general_pin_2_oe_o == $past(r8[5]))
		else $error("pin 2 direction wrong");
	mute_gate_a: assert property ($past(enable_i) |->
		power_stage_mute_o == $past(converter_mute_i && r8[4]))
		else $error("mute gate wrong");
	bclk_dir_a: assert property ($past(enable_i) |-> bit_clock_oe_o == $past(r9[4]))
		else $error("bit clock direction wrong");
	frame_dir_a: assert property ($past(enable_i) |-> frame_clock_oe_o == $past(r9[0]))
		else $error("frame clock direction wrong");
	read_back_a: assert property ($past(enable_i && !reg_write_i) |-> reg_rdata_o == $past(rd))
		else $error("readback wrong");
	bclk_period_a: assert property ($rose(bit_clock_o) ##0 run4[*3] |->
		!bit_clock_o && $past(bit_clock_o))
		else $error("bit clock half period wrong");
	bclk_stop_a: assert property (((!bclk_div_run_i || bclk_div_factor_i < 2) && $stable(r9))[*3]
		|=> $stable(bit_clock_o))
		else $error("bit clock runs while stopped");
	cover property (bit_clock_oe_o && frame_clock_oe_o);
	cover property (power_stage_mute_o);
	cover property (launch_strobe_o);
endmodule
bind apgc_audio_port_ctrl apgc_audio_port_ctrl_monitor #(.DIV_WIDTH(DIV_WIDTH)) mon (
	.clk_i, .reset_i, .enable_i, .reg_write_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
	.bclk_div_run_i, .bclk_div_factor_i, .converter_mute_i, .power_stage_mute_o,
	.general_pin_0_oe_o, .general_pin_2_oe_o, .bit_clock_o, .bit_clock_oe_o,
	.frame_clock_oe_o, .launch_strobe_o);

// ==== sim/apgc_audio_source.sv ====
// Model: audio source that times its samples to the port frame clock
`timescale 1ns/1ps
module apgc_audio_source (
	// Clock and the device's frame clock and direction
	input  wire logic   clk_i,
	input  wire logic   master_i,
	input  wire logic   frame_clock_i,
	// Own clocks; the device uses only the bit clock, and only while it receives it
	output logic        bclk_o,
	output logic        fclk_o,
	// Sample stream toward the device
	output logic        valid_o,
	output logic [15:0] in_o,
	output logic [15:0] proc_o
);
	logic [5:0] div = 6'h00;
	logic       last = 1'b0;
	logic       frame;
	initial begin
		valid_o = 1'b0;
		in_o = 16'h8001;
		proc_o = 16'h7FFE;
	end
	// Own frame clock fclk_o turns exactly when the own bit clock falls
	assign bclk_o = div[1];
	assign fclk_o = div[5];
	assign frame = master_i ? frame_clock_i : div[5];
	always @(negedge clk_i) begin
		div <= div + 6'h01;
		last <= frame;
		valid_o <= frame && !last;
		if (frame && !last) begin
			in_o <= in_o + 16'h1357;
			proc_o <= ~(in_o + 16'h1357);
		end
	end
endmodule

// ==== sim/apgc_audio_port_ctrl_test.sv ====
// Testbench: register access, pin steering, mute gate, filter and master clocks
`timescale 1ns/1ps
module apgc_audio_port_ctrl_test
	import apgc_pkg::*;
();
	// ---------------------------------------------
	// Stimulus, design and source
	// ---------------------------------------------
	logic        clk = 1'b0, rst = 1'b1, en = 1'b1, wr = 1'b0, cw = 1'b0, mute = 1'b0;
	logic        brun = 1'b0, frun = 1'b0, p0 = 1'b1, p2 = 1'b0, sv, p0o, p0e, p2o, p2e;
	logic        pm, bo, boe, fo, foe, ls, sb, sf;
	logic [7:0]  addr = 8'h00, wd = 8'h00, rdat, bfac = 8'h04, ffac = 8'h04, v;
	logic [1:0]  ci = 2'h0, pin_in;
	logic [15:0] cd = 16'h0000, fs, sdo, is, ps, e;
	int          n_fail = 0, checks = 0, nb, nf, nl;
	always #5 clk = ~clk;
	apgc_audio_port_ctrl dut (.clk_i(clk), .reset_i(rst), .enable_i(en), .reg_write_i(wr),
		.reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat), .coef_write_i(cw),
		.coef_index_i(ci), .coef_wdata_i(cd), .bclk_div_run_i(brun), .frame_div_run_i(frun),
		.bclk_div_factor_i(bfac), .frame_div_factor_i(ffac), .sample_valid_i(sv),
		.input_sample_i(is), .processed_sample_i(ps), .filtered_sample_o(fs),
		.serial_data_out_o(sdo), .general_pin_0_i(p0), .general_pin_0_o(p0o),
		.general_pin_0_oe_o(p0e), .general_pin_2_i(p2), .general_pin_2_o(p2o),
		.general_pin_2_oe_o(p2e), .general_pin_in_o(pin_in), .converter_mute_i(mute),
		.power_stage_mute_o(pm), .bit_clock_i(sb), .bit_clock_o(bo), .bit_clock_oe_o(boe),
		.frame_clock_i(sf), .frame_clock_o(fo), .frame_clock_oe_o(foe), .launch_strobe_o(ls));
	apgc_audio_source src (.clk_i(clk), .master_i(foe), .frame_clock_i(fo), .bclk_o(sb),
		.fclk_o(sf), .valid_o(sv), .in_o(is), .proc_o(ps));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		wr = 1'b1;
		addr = a;
		wd = d;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] x);
		@(negedge clk);
		addr = a;
		@(negedge clk);
		chk({8'h00, rdat}, {8'h00, x});
	endtask
	task automatic next_sample(input int n);
		repeat (n) @(posedge sv);
		repeat (3) @(negedge clk);
	endtask
	task automatic count_edges();
		logic pb, pf;
		nb = 0;
		nf = 0;
		nl = 0;
		pb = bo;
		pf = fo;
		repeat (160) begin
			@(negedge clk);
			nb += int'(bo && !pb);
			nf += int'(fo && !pf);
			nl += int'(ls);
			pb = bo;
			pf = fo;
		end
	endtask
	initial begin
		#200us;
		n_fail++;
		wrap_up();
	end
	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		for (int a = 7; a < 11; a++) rreg(a[7:0], 8'h00);
		wreg(8'h07, 8'hEE);
		wreg(8'h08, 8'hC7);
		wreg(8'h09, 8'hCE);
		rreg(8'h07, 8'hEE);
		rreg(8'h09, 8'hCE);
		chk({12'h000, p0e, p2e, boe, foe}, 16'h0000);
		// Writes while frozen must be lost
		@(negedge clk);
		en = 1'b0;
		wreg(8'h08, 8'h28);
		en = 1'b1;
		rreg(8'h08, 8'hC7);
		for (int k = 0; k < 4; k++) begin
			wreg(8'h08, {2'b00, k[1], 1'b0, k[0], 3'b000});
			wreg(8'h07, {7'h00, k[0]});
			next_sample(1);
			e = k[0] ? is : ps;
			chk({14'h0000, p2e, p0e}, {14'h0000, k[1:0]});
			chk(sdo, e);
			chk({14'h0000, pin_in}, {14'h0000, k[1] ? 1'b0 : p2, k[0] ? 1'b0 : p0});
			chk({15'h0000, p0o && p0e}, {15'h0000, e[15] && k[0]});
			chk({15'h0000, p2o && p2e}, {15'h0000, e[15] && k[1]});
		end
		for (int m = 0; m < 4; m++) begin
			wreg(8'h08, {3'b000, m[1], 4'h0});
			mute = m[0];
			repeat (3) @(negedge clk);
			chk({15'h0000, pm}, {15'h0000, m[0] && m[1]});
		end
		wreg(8'h07, 8'h00);
		next_sample(1);
		chk(fs, is);
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			cw = 1'b1;
			ci = i[1:0];
			cd = (i == 3) ? 16'h7FFF : 16'h0000;
			@(negedge clk);
			cw = 1'b0;
		end
		wreg(8'h07, 8'h10);
		next_sample(2);
		chk(fs, 16'h0000);
		@(negedge clk);
		cw = 1'b1;
		ci = 2'h0;
		cd = 16'h4000;
		@(negedge clk);
		cw = 1'b0;
		next_sample(2);
		chk(fs, is);
		wreg(8'h09, 8'h11);
		repeat (2) @(negedge clk);
		chk({14'h0000, boe, foe}, 16'h0003);
		for (int c = 0; c < 4; c++) begin
			@(negedge clk);
			brun = (c != 1);
			frun = (c != 3);
			bfac = (c == 2) ? 8'h01 : 8'h04;
			repeat (40) @(negedge clk);
			count_edges();
			chk(nb[15:0], (c == 0 || c == 3) ? 16'h0028 : 16'h0000);
			chk(nf[15:0], (c == 0) ? 16'h000A : 16'h0000);
			chk(nl[15:0], (c == 0 || c == 3) ? 16'h0028 : 16'h0000);
		end
		brun = 1'b0;
		repeat (4) @(negedge clk);
		v = {7'h00, bo};
		wreg(8'h09, 8'h31);
		repeat (3) @(negedge clk);
		chk({15'h0000, bo}, {15'h0000, ~v[0]});
		// Inverted polarity with the clocks running: launch moves to the rising edge of the divider clock, still the falling edge of bit_clock_o
		brun = 1'b1;
		frun = 1'b1;
		repeat (40) @(negedge clk);
		count_edges();
		chk(nb[15:0], 16'h0028);
		chk(nf[15:0], 16'h000A);
		chk(nl[15:0], 16'h0028);
		wrap_up();
	end
endmodule
